// File: pcd_map.svh
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// Register byte addresses on the bus.
`define PCD_A_CTRL 8'h00
`define PCD_A_MULT 8'h04
`define PCD_A_RDIV 8'h08
`define PCD_A_STS 8'h0c
`define PCD_A_CLR 8'h10
`define PCD_A_IEN 8'h14

// Clock control field positions.
`define PCD_F_LOCK 7
`define PCD_F_PWR 6
`define PCD_F_SRC 5
`define PCD_F_BCS_HI 4
`define PCD_F_BCS_LO 2
`define PCD_F_MCS_HI 1
`define PCD_F_MCS_LO 0

// Reset values.
`define PCD_R_PWR 1'b0
`define PCD_R_SRC 1'b0
`define PCD_R_BCS 3'h0
`define PCD_R_MCS 2'h0
`define PCD_R_CNT12 12'hfff
`define PCD_R_EV 4'h0

// Interrupt status bit positions.
`define PCD_E_LOCK_UP 0
`define PCD_E_LOCK_DN 1
`define PCD_E_DIV 2
`define PCD_E_SRC 3

`endif

// File: pcd_pkg.sv
package pcd_pkg;

    typedef enum logic {
        PCD_SRC_XTAL = 1'b0,
        PCD_SRC_LOOP = 1'b1
    } pcd_src_t;

    typedef logic [3:0] pcd_ev_t;

endpackage

// File: pcd_divider.sv
`timescale 1ns/1ps
`include "pcd_map.svh"

module pcd_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic root_rise_i,
    input wire logic root_lvl_i,
    input wire logic [2:0] bcs_i,
    input wire logic [1:0] mcs_i,
    output logic sys_clk_o,
    output logic bus_clk_o,
    output logic mod_clk_o,
    output logic applied_o
);

    // Tap n of the ripple count: n = 0 is the root itself.
    function automatic logic tap(input logic [10:0] cnt,
                                 input logic [3:0] n,
                                 input logic lvl);
        logic r;
        r = lvl;
        if (n != 4'h0) begin
            r = cnt[n - 4'h1];
        end
        return r;
    endfunction

    logic [10:0] cnt_ff;
    logic [2:0] bcs_ff;
    logic [1:0] mcs_ff;
    logic sys_ff;
    logic bus_ff;
    logic mod_ff;
    logic app_ff;

    wire wrap = root_rise_i & (&cnt_ff);
    wire change = (bcs_i != bcs_ff) | (mcs_i != mcs_ff);
    wire apply = wrap & change;
    wire [3:0] n_sys = {1'b0, bcs_ff};
    wire [3:0] n_bus = n_sys + 4'h1;
    wire [3:0] n_mod = n_bus + {2'b00, mcs_ff};
    wire [10:0] nxt_cnt = root_rise_i ? cnt_ff + 11'h001 : cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // New settings are taken only when every counter tap falls together at the
    // wrap, so no derived clock shows a shortened pulse. The price is a
    // latency of up to 2048 root edges before a change is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bcs_ff <= `PCD_R_BCS;
            mcs_ff <= `PCD_R_MCS;
        end else if (apply) begin
            bcs_ff <= bcs_i;
            mcs_ff <= mcs_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 11'h000;
            app_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            app_ff <= apply;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_ff <= 1'b0;
            bus_ff <= 1'b0;
            mod_ff <= 1'b0;
        end else begin
            sys_ff <= tap(cnt_ff, n_sys, root_lvl_i);
            bus_ff <= tap(cnt_ff, n_bus, root_lvl_i);
            mod_ff <= tap(cnt_ff, n_mod, root_lvl_i);
        end
    end

    assign sys_clk_o = sys_ff;
    assign bus_clk_o = bus_ff;
    assign mod_clk_o = mod_ff;
    assign applied_o = app_ff;

    a_apply_at_wrap: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $changed(bcs_ff) |-> $past(root_rise_i) && $past(&cnt_ff)
    ) else $error("divider setting changed away from the wrap");

    a_bus_from_sys: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bcs_ff != 3'h0 && $stable(bcs_ff) && $rose(bus_ff))
            |-> $fell(sys_ff)
    ) else $error("bus clock is not half the system clock");

endmodule

// File: pcd_clock_ctrl.sv
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "pcd_map.svh"

module pcd_clock_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic xtal_clk_i,
    input wire logic loop_clk_i,
    output logic loop_power_o,
    output logic [11:0] loop_mult_o,
    output logic ref_clock_o,
    output logic sys_clock_o,
    output logic bus_clock_o,
    output logic module_clock_o,
    output logic irq_o
);

    // Byte-lane merge for the 12-bit count registers.
    function automatic logic [11:0] merge12(input logic [11:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        logic [11:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[11:8] = d[11:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers. Both root clocks are sampled by clk_i, so they
    // must run no faster than 6.25 MHz for each level to be seen.
    logic [1:0] sy1_ff;
    logic [1:0] sy2_ff;
    logic [1:0] sy3_ff;
    logic [1:0] lvl_ff;
    logic [1:0] nxt_lvl;

    assign nxt_lvl[0] = (sy2_ff[0] == sy3_ff[0]) ? sy3_ff[0] : lvl_ff[0];
    assign nxt_lvl[1] = (sy2_ff[1] == sy3_ff[1]) ? sy3_ff[1] : lvl_ff[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1_ff <= 2'b00;
            sy2_ff <= 2'b00;
            sy3_ff <= 2'b00;
            lvl_ff <= 2'b00;
        end else begin
            sy1_ff <= {loop_clk_i, xtal_clk_i};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    wire xtal_rise = nxt_lvl[0] & ~lvl_ff[0];
    wire loop_rise = nxt_lvl[1] & ~lvl_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Register bus. One wait state: ack follows the request by one edge,
    // and writes commit on the edge that the master sees ack.
    logic ack_ff;
    logic [31:0] dat_ff;
    logic pwr_ff;
    logic src_ff;
    logic [2:0] bcs_ff;
    logic [1:0] mcs_ff;
    logic [11:0] mult_ff;
    logic [11:0] rdiv_ff;
    logic lock_ff;
    pcd_pkg::pcd_ev_t sts_ff;
    pcd_pkg::pcd_ev_t ien_ff;
    logic irq_ff;

    wire req = cyc_i & stb_i;
    wire rd_go = req & ~ack_ff;
    wire wr_go = req & we_i & ack_ff;
    wire hit_ctrl = adr_i == `PCD_A_CTRL;
    wire hit_mult = adr_i == `PCD_A_MULT;
    wire hit_rdiv = adr_i == `PCD_A_RDIV;
    wire hit_sts = adr_i == `PCD_A_STS;
    wire hit_clr = adr_i == `PCD_A_CLR;
    wire hit_ien = adr_i == `PCD_A_IEN;
    wire wr_ctrl = wr_go & hit_ctrl & sel_i[0];
    wire [7:0] ctrl_rd = {lock_ff, pwr_ff, src_ff, bcs_ff, mcs_ff};
    wire [31:0] rdata =
        hit_ctrl ? {24'h000000, ctrl_rd} :
        hit_mult ? {20'h00000, mult_ff} :
        hit_rdiv ? {20'h00000, rdiv_ff} :
        hit_sts ? {28'h0000000, sts_ff} :
        hit_ien ? {28'h0000000, ien_ff} : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= rd_go;
            if (rd_go) begin
                dat_ff <= rdata;
            end
        end
    end

    // No write-once or mode gating: any write that selects byte lane 0 lands.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_ff <= `PCD_R_PWR;
            src_ff <= `PCD_R_SRC;
            bcs_ff <= `PCD_R_BCS;
            mcs_ff <= `PCD_R_MCS;
        end else if (wr_ctrl) begin
            pwr_ff <= dat_i[`PCD_F_PWR];
            src_ff <= dat_i[`PCD_F_SRC];
            bcs_ff <= dat_i[`PCD_F_BCS_HI:`PCD_F_BCS_LO];
            mcs_ff <= dat_i[`PCD_F_MCS_HI:`PCD_F_MCS_LO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mult_ff <= `PCD_R_CNT12;
            rdiv_ff <= `PCD_R_CNT12;
            ien_ff <= `PCD_R_EV;
        end else begin
            if (wr_go & hit_mult) begin
                mult_ff <= merge12(mult_ff, dat_i, sel_i);
            end
            if (wr_go & hit_rdiv) begin
                rdiv_ff <= merge12(rdiv_ff, dat_i, sel_i);
            end
            if (wr_go & hit_ien & sel_i[0]) begin
                ien_ff <= dat_i[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detection. Over one reference window (rdiv crystal edges) the
    // loop should give mult edges; lock means the count lies in
    // [mult/2, 2*mult]. The edge counter saturates instead of wrapping.
    // A window count already past a newly lowered limit ends on the next
    // crystal edge rather than running all the way round the 12-bit range.
    logic [11:0] xcnt_ff;
    logic [12:0] lcnt_ff;
    logic refc_ff;

    wire [11:0] rdiv_last = (rdiv_ff == 12'h000) ? 12'h000 :
                            rdiv_ff - 12'h001;
    wire win_end = xtal_rise & (xcnt_ff >= rdiv_last);
    wire [13:0] lcnt_x2 = {lcnt_ff, 1'b0};
    wire [12:0] mult_x2 = {mult_ff, 1'b0};
    wire in_band = (lcnt_x2 >= {2'b00, mult_ff}) & (lcnt_ff <= mult_x2);
    wire [12:0] lcnt_inc = (&lcnt_ff) ? lcnt_ff : lcnt_ff + 13'h0001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xcnt_ff <= 12'h000;
            refc_ff <= 1'b0;
        end else begin
            if (win_end) begin
                xcnt_ff <= 12'h000;
            end else if (xtal_rise) begin
                xcnt_ff <= xcnt_ff + 12'h001;
            end
            refc_ff <= xcnt_ff < {1'b0, rdiv_ff[11:1]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lcnt_ff <= 13'h0000;
            lock_ff <= 1'b0;
        end else if (!pwr_ff) begin
            lcnt_ff <= 13'h0000;
            lock_ff <= 1'b0;
        end else if (win_end) begin
            lcnt_ff <= 13'h0000;
            lock_ff <= in_band;
        end else if (loop_rise) begin
            lcnt_ff <= lcnt_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Root source mux. The switch waits until both roots are low so the
    // edge detector never sees a false rise across the change. Losing
    // lock drops back to the crystal.
    pcd_pkg::pcd_src_t act_ff;
    pcd_pkg::pcd_src_t want;
    logic act_sw_ff;

    assign want = (src_ff & lock_ff) ? pcd_pkg::PCD_SRC_LOOP :
                  pcd_pkg::PCD_SRC_XTAL;
    wire quiet = ~lvl_ff[0] & ~lvl_ff[1] & ~nxt_lvl[0] & ~nxt_lvl[1];
    wire do_sw = (want != act_ff) & quiet;
    wire on_loop = act_ff == pcd_pkg::PCD_SRC_LOOP;
    wire root_rise = on_loop ? loop_rise : xtal_rise;
    wire root_lvl = on_loop ? lvl_ff[1] : lvl_ff[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_ff <= pcd_pkg::PCD_SRC_XTAL;
            act_sw_ff <= 1'b0;
        end else begin
            if (do_sw) begin
                act_ff <= want;
            end
            act_sw_ff <= do_sw;
        end
    end

    logic div_app;
    logic sys_clk;
    logic bus_clk;
    logic mod_clk;

    pcd_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .root_rise_i(root_rise),
        .root_lvl_i(root_lvl),
        .bcs_i(bcs_ff),
        .mcs_i(mcs_ff),
        .sys_clk_o(sys_clk),
        .bus_clk_o(bus_clk),
        .mod_clk_o(mod_clk),
        .applied_o(div_app)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupts. A new event in the clearing cycle survives the clear.
    logic lock_d_ff;
    pcd_pkg::pcd_ev_t ev;
    pcd_pkg::pcd_ev_t clr;
    pcd_pkg::pcd_ev_t nxt_sts;

    assign ev[`PCD_E_LOCK_UP] = lock_ff & ~lock_d_ff;
    assign ev[`PCD_E_LOCK_DN] = ~lock_ff & lock_d_ff;
    assign ev[`PCD_E_DIV] = div_app;
    assign ev[`PCD_E_SRC] = act_sw_ff;
    assign clr = (wr_go & hit_clr & sel_i[0]) ? dat_i[3:0] : 4'h0;
    assign nxt_sts = (sts_ff & ~clr) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_d_ff <= 1'b0;
            sts_ff <= `PCD_R_EV;
            irq_ff <= 1'b0;
        end else begin
            lock_d_ff <= lock_ff;
            sts_ff <= nxt_sts;
            irq_ff <= |(nxt_sts & ien_ff);
        end
    end

    logic sys_ff;
    logic bus_ff;
    logic mod_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_ff <= 1'b0;
            bus_ff <= 1'b0;
            mod_ff <= 1'b0;
        end else begin
            sys_ff <= sys_clk;
            bus_ff <= bus_clk;
            mod_ff <= mod_clk;
        end
    end

    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign loop_power_o = pwr_ff;
    assign loop_mult_o = mult_ff;
    assign ref_clock_o = refc_ff;
    assign sys_clock_o = sys_ff;
    assign bus_clock_o = bus_ff;
    assign module_clock_o = mod_ff;
    assign irq_o = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    default clocking dflt_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_lock_off_power: assert property (
        !pwr_ff |=> !lock_ff
    ) else $error("lock shown while loop is off");

    a_lock_from_band: assert property (
        $rose(lock_ff) |-> $past(win_end) && $past(in_band)
    ) else $error("lock set outside a window in band");

    a_power_write: assert property (
        wr_ctrl |=> ##1 loop_power_o == $past(dat_i[`PCD_F_PWR], 2)
    ) else $error("power output does not follow write");

    a_loop_needs_lock: assert property (
        $rose(act_ff) |-> $past(lock_ff) && $past(src_ff)
    ) else $error("loop chosen without lock");

    a_switch_quiet: assert property (
        $changed(act_ff) |-> $past(quiet)
    ) else $error("root switched while a root was high");

    a_fields_together: assert property (
        wr_ctrl |=>
            bcs_ff == $past(dat_i[`PCD_F_BCS_HI:`PCD_F_BCS_LO]) &&
            mcs_ff == $past(dat_i[`PCD_F_MCS_HI:`PCD_F_MCS_LO])
    ) else $error("divider fields not written together");

    a_ack_answer: assert property (
        rd_go |=> ack_o ##1 !ack_o
    ) else $error("bus answer not one wait state");

    a_irq_level: assert property (
        irq_o == |(sts_ff & $past(ien_ff))
    ) else $error("interrupt output not tied to status");

    a_ref_window: assert property (
        win_end |=> xcnt_ff == 12'h000
    ) else $error("reference window did not restart");

endmodule

// File: pcd_root_model.sv
`timescale 1ns/1ps

// Crystal and loop core. The loop runs at xtal * mult / rdiv while powered.
module pcd_root_model #(
    parameter int XTAL_HALF_NS = 480
) (
    input wire logic power_i,
    input wire logic [11:0] mult_i,
    input wire logic [11:0] rdiv_i,
    input wire logic slow_i,
    output logic xtal_clk_o,
    output logic loop_clk_o
);

    ////////////////////////////////////////////////////////////////////////
    // Edges sit a few ns after a system edge so the sampling is never a race.
    initial begin
        xtal_clk_o = 1'b0;
        #7;
        forever #(XTAL_HALF_NS) xtal_clk_o = ~xtal_clk_o;
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow mode runs the loop at a quarter of its target so lock never comes.
    function automatic int loop_half();
        int h;
        h = XTAL_HALF_NS * rdiv_i / ((mult_i == 12'h000) ? 1 : mult_i);
        if (slow_i === 1'b1) begin
            h = h * 4;
        end
        return (h < 80) ? 80 : h;
    endfunction

    initial begin
        loop_clk_o = 1'b0;
        forever begin
            if (power_i !== 1'b1) begin
                loop_clk_o = 1'b0;
                @(posedge power_i);
                #3;
            end
            #(loop_half()) loop_clk_o = ~loop_clk_o;
        end
    end

endmodule

// File: pll_clock_select_and_divide_bench.sv
`timescale 1ns/1ps
`include "pcd_map.svh"

module pll_clock_select_and_divide_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [3:0] wsel = 4'hf;
    logic [31:0] dat_o;
    logic ack_o;
    logic xtal_clk;
    logic loop_clk;
    logic loop_power;
    logic [11:0] loop_mult;
    logic ref_clock;
    logic sys_clock;
    logic bus_clock;
    logic module_clock;
    logic irq_o;
    logic slow = 1'b0;
    logic [31:0] rd;
    logic [7:0] cv [3] = '{8'h6b, 8'h6e, 8'h7c};
    int sx [3] = '{24, 48, 768};
    int error_cnt = 0;
    int total_checks = 0;
    int cycle_cnt = 0;

    always #20 clk_i = ~clk_i;

    pcd_clock_ctrl dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .xtal_clk_i(xtal_clk),
        .loop_clk_i(loop_clk), .loop_power_o(loop_power),
        .loop_mult_o(loop_mult), .ref_clock_o(ref_clock),
        .sys_clock_o(sys_clock), .bus_clock_o(bus_clock),
        .module_clock_o(module_clock), .irq_o(irq_o)
    );

    pcd_root_model root_u (
        .power_i(loop_power), .mult_i(loop_mult), .rdiv_i(12'h004),
        .slow_i(slow), .xtal_clk_o(xtal_clk), .loop_clk_o(loop_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycle_cnt++;
        if (cycle_cnt == 90000) begin
            error_cnt++;
            finish_test();
        end
    end

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled high.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= a;
        sel_i <= wsel;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        check("ack", {31'h0, ack_o}, 32'h1);
    endtask

    task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(name, rd, e);
    endtask

    task poll(input logic [7:0] a, input int b, input int lim);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < lim);
        check("poll", {31'h0, rd[b]}, 32'h1);
    endtask

    // Average of two periods of a derived clock, in system cycles.
    task meas(input string name, input int which, input int exp);
        logic prev;
        logic cur;
        int n;
        int rises;
        int t0;
        prev = 1'b1;
        rises = 0;
        n = 0;
        t0 = 0;
        while (rises < 3 && n < 20000) begin
            @(posedge clk_i);
            n++;
            cur = (which == 0) ? sys_clock : (which == 1) ? bus_clock :
                  (which == 2) ? module_clock : ref_clock;
            if (cur === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 1) begin
                    t0 = n;
                end
            end
            prev = cur;
        end
        check(name, (n - t0) / 2, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("ctrl", `PCD_A_CTRL, 32'h00);
        rdc("mult", `PCD_A_MULT, 32'hfff);
        rdc("rdiv", `PCD_A_RDIV, 32'hfff);
        rdc("status", `PCD_A_STS, 32'h0);
        rdc("enable", `PCD_A_IEN, 32'h0);
        rdc("unmapped", 8'h1c, 32'h0);
        check("power", {31'h0, loop_power}, 32'h0);
        meas("sys", 0, 24);
        meas("bus", 1, 48);
        meas("module", 2, 48);
        $display("Test reset values done");
        wb(1'b1, `PCD_A_RDIV, 32'h4);
        wb(1'b1, `PCD_A_MULT, 32'h10);
        rdc("rdiv", `PCD_A_RDIV, 32'h4);
        check("mult out", {20'h0, loop_mult}, 32'h10);
        meas("ref", 3, 96);
        $display("Test loop counts done");
        // A loop far below target must not be chosen as root.
        slow <= 1'b1;
        wb(1'b1, `PCD_A_CTRL, 32'h60);
        @(posedge clk_i);
        check("power", {31'h0, loop_power}, 32'h1);
        repeat (400) @(posedge clk_i);
        rdc("ctrl", `PCD_A_CTRL, 32'h60);
        meas("sys", 0, 24);
        $display("Test no lock done");
        slow <= 1'b0;
        poll(`PCD_A_STS, `PCD_E_SRC, 300);
        rdc("ctrl", `PCD_A_CTRL, 32'he0);
        meas("sys", 0, 6);
        wb(1'b0, `PCD_A_STS, 32'h0);
        check("status", rd & 32'hb, 32'h9);
        check("irq", {31'h0, irq_o}, 32'h0);
        wb(1'b1, `PCD_A_IEN, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h1);
        wb(1'b1, `PCD_A_CLR, 32'hf);
        repeat (2) @(posedge clk_i);
        check("irq", {31'h0, irq_o}, 32'h0);
        rdc("enable", `PCD_A_IEN, 32'h1);
        $display("Test lock done");
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `PCD_A_CTRL, {24'h0, cv[i]});
            poll(`PCD_A_STS, `PCD_E_DIV, 5000);
            rdc("ctrl", `PCD_A_CTRL, {24'h0, cv[i] | 8'h80});
            meas("sys", 0, sx[i]);
            if (i == 0) begin
                meas("bus", 1, 48);
            end
            if (i < 2) begin
                meas("module", 2, 384);
            end
            wb(1'b1, `PCD_A_CLR, 32'h4);
        end
        $display("Test dividers done");
        // Power off drops lock and must fall back to the crystal.
        wb(1'b1, `PCD_A_CTRL, 32'h3c);
        poll(`PCD_A_STS, `PCD_E_LOCK_DN, 100);
        poll(`PCD_A_STS, `PCD_E_SRC, 100);
        rdc("ctrl", `PCD_A_CTRL, 32'h3c);
        check("power", {31'h0, loop_power}, 32'h0);
        meas("sys", 0, 3072);
        wsel = 4'h1;
        wb(1'b1, `PCD_A_MULT, 32'hfab);
        rdc("mult low", `PCD_A_MULT, 32'h0ab);
        wsel = 4'h2;
        wb(1'b1, `PCD_A_MULT, 32'h3cd);
        rdc("mult high", `PCD_A_MULT, 32'h3ab);
        wsel = 4'hf;
        $display("Test power off done");
        finish_test();
    end

endmodule
